/* hw/ddr2_rd_seq.sv */
// Read-side command sequencer of a DDR2 device: read latency, burst output,
// truncation by READ, and per-bank auto precharge with concurrent operation.
// Assumes commands are sampled on every rising mclk edge and mode is static.
`timescale 1ns/1ps
`default_nettype none

module ddr2_rd_seq (
    input wire logic mclk,
    input wire logic rst,
    input wire ddr2_rd_pkg::cmd_s cmd,
    input wire ddr2_rd_pkg::mode_s mode,
    output ddr2_rd_pkg::rd_out_s rd_out,
    output logic [ddr2_rd_pkg::NUM_BANKS-1:0] ap_fire,
    output logic [ddr2_rd_pkg::NUM_BANKS-1:0] bank_ready,
    output logic seq_err
);
    import ddr2_rd_pkg::*;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    wire logic is_read = (cmd.op == CMD_READ);
    wire logic is_write = (cmd.op == CMD_WRITE);
    wire logic is_pre = (cmd.op == CMD_PRECHARGE);
    wire logic is_act = (cmd.op == CMD_ACTIVATE);
    wire logic [CNT_W-1:0] half_bl = mode.bl8 ? HALF_BL8 : HALF_BL4;
    wire logic [3:0] rl = {1'b0, mode.al} + {1'b0, mode.cl};
    wire logic [CNT_W-1:0] al_w = {3'h0, mode.al};

    // ****************************************************************
    // Spacing since the last READ
    // ****************************************************************
    logic [CNT_W-1:0] since_read;
    logic prev_cuttable;
    wire logic in_burst = since_read < half_bl;
    // only BL8 without AP, cut on prefetch edge
    wire logic legal_cut = prev_cuttable && (since_read == INTERRUPT_GAP);
    // reads closer than BL/2 are a breach
    wire logic bad_read = is_read && in_burst && !legal_cut;
    // no write or precharge into an open burst
    wire logic bad_other = (is_write || is_pre) && in_burst;
    wire logic next_seq_err = bad_read || bad_other;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            since_read <= 6'h3f;
            prev_cuttable <= 1'b0;
            seq_err <= 1'b0;
        end
        else
        begin
            since_read <= is_read ? 6'h01 : (since_read == 6'h3f ? since_read : since_read + 6'h01);
            if (is_read)
            begin
                prev_cuttable <= mode.bl8 && !cmd.auto_pre;
            end
            seq_err <= next_seq_err;
        end
    end

    // ****************************************************************
    // Read latency pipeline and burst output
    // ****************************************************************
    pipe_s [PIPE_DEPTH-1:0] rd_pipe;
    wire pipe_s next_entry = '{valid: is_read, bank: cmd.bank, col: cmd.col};
    // tap selects the read issued RL-1 clocks ago, so rd_out starts RL clocks after READ
    wire pipe_s tap = rd_pipe[rl - 4'h1];
    logic [CNT_W-1:0] beats_left;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_pipe <= '0;
        end
        else
        begin
            rd_pipe <= {rd_pipe[PIPE_DEPTH-2:0], next_entry};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_out <= '0;
            beats_left <= 6'h00;
        end
        else if (tap.valid)
        begin
            // a newer burst replaces the one in flight
            rd_out <= '{valid: 1'b1, start: 1'b1, last: 1'b0, bank: tap.bank, col: tap.col};
            beats_left <= half_bl - 6'h01;
        end
        else if (beats_left != 6'h00)
        begin
            rd_out.start <= 1'b0;
            rd_out.col <= rd_out.col + COL_STEP;
            rd_out.last <= (beats_left == 6'h01);
            beats_left <= beats_left - 6'h01;
        end
        else
        begin
            rd_out <= '0;
        end
    end

    // ****************************************************************
    // Per-bank timers and auto precharge
    // ****************************************************************
    logic [CNT_W-1:0] ras_cnt [NUM_BANKS];
    logic [CNT_W-1:0] rtp_cnt [NUM_BANKS];
    logic [CNT_W-1:0] ap_wait [NUM_BANKS];
    logic [CNT_W-1:0] rp_cnt [NUM_BANKS];
    logic [NUM_BANKS-1:0] ap_pend;
    // last prefetch is AL, or AL+2 for BL8
    wire logic [CNT_W-1:0] rtp_load = al_w + (mode.bl8 ? LAST_PREFETCH_BL8 : 6'h00) + RTP_LOAD;
    wire logic [CNT_W-1:0] ap_load = al_w + half_bl - 6'h01;

    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++)
        begin : g_bank
            wire logic hit = (cmd.bank == BANK_W'(b));
            // fire only when AL+BL/2, tRAS and tRTP all met
            assign ap_fire[b] = ap_pend[b] && (ap_wait[b] == 6'h00) && (ras_cnt[b] == 6'h00)
                && (rtp_cnt[b] == 6'h00);
            assign bank_ready[b] = !ap_pend[b] && (rp_cnt[b] == 6'h00);

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    ras_cnt[b] <= 6'h00;
                    rtp_cnt[b] <= 6'h00;
                    ap_wait[b] <= 6'h00;
                    rp_cnt[b] <= 6'h00;
                    ap_pend[b] <= 1'b0;
                end
                else
                begin
                    ras_cnt[b] <= (hit && is_act) ? RAS_LOAD : (ras_cnt[b] != 6'h00 ? ras_cnt[b] - 6'h01 : 6'h00);
                    // tRTP floor of two clocks after last prefetch
                    rtp_cnt[b] <= (hit && is_read) ? rtp_load : (rtp_cnt[b] != 6'h00 ? rtp_cnt[b] - 6'h01 : 6'h00);
                    // A10 on READ arms auto precharge
                    if (hit && is_read && cmd.auto_pre)
                    begin
                        ap_pend[b] <= 1'b1;
                        ap_wait[b] <= ap_load;
                    end
                    else
                    begin
                        ap_pend[b] <= ap_pend[b] && !ap_fire[b];
                        ap_wait[b] <= (ap_wait[b] != 6'h00) ? ap_wait[b] - 6'h01 : 6'h00;
                    end
                    // tRP counted from the actual firing edge
                    if (ap_fire[b] || (hit && is_pre))
                    begin
                        rp_cnt[b] <= RP_LOAD;
                    end
                    else
                    begin
                        rp_cnt[b] <= (rp_cnt[b] != 6'h00) ? rp_cnt[b] - 6'h01 : 6'h00;
                    end
                end
            end

            // no firing in the 8 clocks after ACTIVATE
            chk_ap_timers_met: assert property (@(posedge mclk) disable iff (rst)
                hit && is_act |=> !ap_fire[b] [*8])
                else $error("auto precharge fired before row-active time");
            // bank stays busy a full tRP after firing
            chk_rp_after_fire: assert property (@(posedge mclk) disable iff (rst)
                ap_fire[b] && !(hit && is_read && cmd.auto_pre) |=> !bank_ready[b] [*3])
                else $error("bank ready before precharge time");
            // no firing within two clocks of a read, one clock for BL4 with AL 0
            chk_ap_not_early: assert property (@(posedge mclk) disable iff (rst)
                hit && is_read |=> !ap_fire[b] ##1 (!ap_fire[b] || (mode.al == 3'h0 && !mode.bl8)))
                else $error("auto precharge too soon after read");
            // A10 read arms the bank on the next edge
            chk_ap_decode: assert property (@(posedge mclk) disable iff (rst)
                hit && is_read && cmd.auto_pre |=> ap_pend[b] && !bank_ready[b])
                else $error("auto precharge not armed");
        end
    endgenerate

    // ****************************************************************
    // Checks on sequencing
    // ****************************************************************
    sequence s_bl8_read;
        is_read && mode.bl8 && !cmd.auto_pre;
    endsequence

    sequence s_cut_at_two;
        !is_read ##1 is_read;
    endsequence

    // cut exactly on the prefetch edge is accepted
    chk_legal_cut: assert property (@(posedge mclk) disable iff (rst)
        s_bl8_read ##1 s_cut_at_two |=> !seq_err)
        else $error("legal read interrupt flagged");
    // a BL4 read cannot be cut by another read
    chk_bl4_no_cut: assert property (@(posedge mclk) disable iff (rst)
        is_read && !mode.bl8 ##1 is_read |=> seq_err)
        else $error("BL4 burst cut without error");
    // precharge inside a burst is reported
    chk_pre_in_burst: assert property (@(posedge mclk) disable iff (rst)
        is_read ##1 is_pre |=> seq_err)
        else $error("precharge during read burst not flagged");
    // READ to another bank BL/2 after AP read accepted
    chk_concurrent: assert property (@(posedge mclk) disable iff (rst)
        is_read && cmd.auto_pre && mode.bl8 ##1 !is_read [*3] ##1 (is_read && cmd.bank != $past(cmd.bank, 4))
            |=> !seq_err)
        else $error("concurrent command refused");
    // a BL4 burst spans two clocks, last on the second
    chk_burst_span: assert property (@(posedge mclk) disable iff (rst)
        rd_out.start && !mode.bl8 && !tap.valid |=> rd_out.valid && rd_out.last)
        else $error("BL4 burst length wrong");

endmodule : ddr2_rd_seq

`default_nettype wire

/* hw/ddr2_rd_pkg.sv */
// Shared types and constants for the DDR2 read-side sequencer.
// Assumes one 250 MHz clock and a mode that is held steady while commands flow.
package ddr2_rd_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int COL_W = 10;
    localparam int CNT_W = 6;
    localparam int PIPE_DEPTH = 16;

    // ****************************************************************
    // Timing: figures in ps, counts rounded up to whole clocks
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_RAS_PS = 40000;
    localparam int T_RTP_PS = 7500;
    localparam int T_RP_PS = 15000;
    localparam int T_RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RTP_CYC = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_RTP_CYC = 2;
    localparam int RTP_EFF_CYC = (T_RTP_CYC > MIN_RTP_CYC) ? T_RTP_CYC : MIN_RTP_CYC;
    localparam logic [CNT_W-1:0] RAS_LOAD = CNT_W'(T_RAS_CYC - 1);
    localparam logic [CNT_W-1:0] RTP_LOAD = CNT_W'(RTP_EFF_CYC - 1);
    localparam logic [CNT_W-1:0] RP_LOAD = CNT_W'(T_RP_CYC - 1);

    // ****************************************************************
    // Burst figures in clocks, and the column step per clock
    // ****************************************************************
    localparam logic [CNT_W-1:0] HALF_BL4 = 6'h02;
    localparam logic [CNT_W-1:0] HALF_BL8 = 6'h04;
    localparam logic [CNT_W-1:0] INTERRUPT_GAP = 6'h02;
    localparam logic [CNT_W-1:0] LAST_PREFETCH_BL8 = 6'h02;
    localparam logic [COL_W-1:0] COL_STEP = 10'h002;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_ACTIVATE
    } cmd_op_e;

    typedef struct packed {
        cmd_op_e op;
        logic [BANK_W-1:0] bank;
        logic auto_pre;
        logic [COL_W-1:0] col;
    } cmd_s;

    typedef struct packed {
        logic bl8;
        logic [2:0] al;
        logic [2:0] cl;
    } mode_s;

    typedef struct packed {
        logic valid;
        logic start;
        logic last;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } rd_out_s;

    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } pipe_s;

endpackage : ddr2_rd_pkg

/* sim/ddr2_ctrl_model.sv */
// Behavioural memory controller that drives one command per clock.
// Assumes the bench calls its tasks from a falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none

module ddr2_ctrl_model (
    input wire logic mclk,
    output var ddr2_rd_pkg::cmd_s cmd
);
    import ddr2_rd_pkg::*;

    initial cmd = '0;

    // ****************************************************************
    // Command tasks
    // ****************************************************************
    // spacing set by caller
    task automatic issue(input cmd_op_e op, input logic [2:0] bank, input logic ap, input logic [9:0] col);
        cmd <= '{op: op, bank: bank, auto_pre: ap, col: col};
        @(negedge mclk);
    endtask : issue

    task automatic nop(input int n);
        cmd <= '0;
        repeat (n) @(negedge mclk);
    endtask : nop
endmodule : ddr2_ctrl_model

`default_nettype wire

/* sim/ddr2_rd_burst_sequencing_tb.sv */
// Self-checking bench for the DDR2 read-side sequencer.
// Assumes the controller model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module ddr2_read_burst_sequencing_tb;
    import ddr2_rd_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    mode_s mode = '{bl8: 1'b0, al: 3'h1, cl: 3'h3};
    cmd_s cmd;
    rd_out_s rd_out;
    logic [7:0] ap_fire;
    logic [7:0] bank_ready;
    logic seq_err;
    int err_count = 0;
    int compares = 0;
    int errs;
    int fire;
    rd_out_s trc [0:31];
    logic rdy [0:31];

    always #2 mclk = ~mclk;

    ddr2_ctrl_model ctrl (.mclk(mclk), .cmd(cmd));

    ddr2_rd_seq dut (.mclk(mclk), .rst(rst), .cmd(cmd), .mode(mode), .rd_out(rd_out),
        .ap_fire(ap_fire), .bank_ready(bank_ready), .seq_err(seq_err));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic restart(input logic bl8);
        rst = 1'b1;
        mode.bl8 = bl8;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
    endtask : restart

    // Drive NOPs and record from the negedge right after the last command
    task automatic obs(input int n, input int wb);
        errs = 0;
        fire = -1;
        fork
            ctrl.nop(n);
            for (int j = 0; j < n; j++)
            begin
                trc[j] = rd_out;
                rdy[j] = bank_ready[wb];
                errs += int'(seq_err);
                if (ap_fire[wb] === 1'b1 && fire < 0)
                    fire = j;
                @(negedge mclk);
            end
        join
    endtask : obs

    task automatic burst(input int j0, input logic [2:0] bank, input logic [9:0] col, input int len, input bit lc);
        for (int i = 0; i < len; i++)
        begin
            check("valid", trc[j0+i].valid, 1'b1);
            check("start", trc[j0+i].start, i == 0);
            if (lc)
                check("last", trc[j0+i].last, i == len - 1);
            check("bank", trc[j0+i].bank, bank);
            check("col", trc[j0+i].col, col + 10'(2 * i));
        end
    endtask : burst

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // seamless BL4 reads
    task automatic seamless_bl4();
        ctrl.issue(CMD_READ, 3'h0, 1'b0, 10'h010);
        ctrl.nop(1);
        ctrl.issue(CMD_READ, 3'h1, 1'b0, 10'h020);
        obs(10, 0);
        burst(2, 3'h0, 10'h010, 2, 1'b1);
        burst(4, 3'h1, 10'h020, 2, 1'b1);
        check("valid end", trc[6].valid, 1'b0);
        check("seq_err", errs, 0);
    endtask : seamless_bl4

    task automatic early_cmds();
        cmd_op_e ops [3] = '{CMD_READ, CMD_WRITE, CMD_PRECHARGE};
        for (int i = 0; i < 3; i++)
        begin
            ctrl.issue(CMD_READ, 3'h0, 1'b0, 10'h000);
            ctrl.issue(ops[i], 3'h0, 1'b0, 10'h000);
            obs(8, 0);
            check("seq_err early", errs, 1);
        end
    endtask : early_cmds

    task automatic auto_pre();
        restart(1'b0);
        ctrl.issue(CMD_READ, 3'h2, 1'b1, 10'h030);
        obs(14, 2);
        check("ready low", rdy[0], 1'b0);
        check("fire time", fire, 2);
        check("ready late", rdy[fire+3], 1'b0);
        check("ready back", rdy[1 + 2 - 2 + (T_RTP_PS + T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS - 1], 1'b1);
        burst(4, 3'h2, 10'h030, 2, 1'b1);
    endtask : auto_pre

    // deferral by row-active time, other bank in use
    task automatic ras_defer();
        restart(1'b0);
        ctrl.issue(CMD_ACTIVATE, 3'h3, 1'b0, 10'h000);
        ctrl.issue(CMD_READ, 3'h3, 1'b1, 10'h000);
        ctrl.issue(CMD_ACTIVATE, 3'h4, 1'b0, 10'h000);
        obs(16, 3);
        check("ras fire", fire, T_RAS_CYC - 3);
        check("seq_err conc", errs, 0);
    endtask : ras_defer

    // BL8 read cut by read two clocks later
    task automatic bl8_cut();
        restart(1'b1);
        ctrl.issue(CMD_READ, 3'h0, 1'b0, 10'h040);
        ctrl.nop(1);
        ctrl.issue(CMD_READ, 3'h5, 1'b1, 10'h080);
        obs(12, 5);
        check("seq_err cut", errs, 0);
        burst(2, 3'h0, 10'h040, 2, 1'b0);
        burst(4, 3'h5, 10'h080, 4, 1'b1);
        check("valid end", trc[8].valid, 1'b0);
        ctrl.issue(CMD_READ, 3'h0, 1'b0, 10'h000);
        ctrl.nop(2);
        ctrl.issue(CMD_READ, 3'h1, 1'b0, 10'h000);
        obs(10, 1);
        check("seq_err off", errs, 1);
    endtask : bl8_cut

    task automatic pre_spacing();
        int rtp = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        int rtp_rp = (T_RTP_PS + T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        mode.al = 3'h2;
        restart(1'b1);
        ctrl.issue(CMD_READ, 3'h6, 1'b0, 10'h100);
        ctrl.nop(2 + 4 - 2 + ((rtp > 2) ? rtp : 2) - 1);
        ctrl.issue(CMD_PRECHARGE, 3'h6, 1'b0, 10'h000);
        obs(8, 6);
        check("seq_err pre", errs, 0);
        check("busy in tRP", rdy[T_RP_CYC-2], 1'b0);
        check("ready after tRP", rdy[T_RP_CYC-1], 1'b1);
        ctrl.issue(CMD_READ, 3'h7, 1'b1, 10'h200);
        ctrl.issue(CMD_ACTIVATE, 3'h6, 1'b0, 10'h000);
        ctrl.nop(2);
        ctrl.issue(CMD_READ, 3'h6, 1'b0, 10'h010);
        obs(12, 7);
        check("seq_err cross", errs, 0);
        check("fire bl8", fire, 1);
        check("ready act bl8", rdy[2 + 4 - 2 + rtp_rp - 5], 1'b1);
        burst(1, 3'h7, 10'h200, 4, 1'b1);
        burst(5, 3'h6, 10'h010, 4, 1'b1);
        check("valid end bl8", trc[9].valid, 1'b0);
    endtask : pre_spacing

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (3000) @(posedge mclk);
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        seamless_bl4();
        early_cmds();
        auto_pre();
        ras_defer();
        bl8_cut();
        pre_spacing();
        stop_test();
    end
endmodule : ddr2_read_burst_sequencing_tb

`default_nettype wire
